// file: design/timer2_waveform_control.sv
`timescale 1ns/100ps
`include "timer2_regs.svh"

module timer2_waveform_control
  import timer2_pkg::*;
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // register port
  input  wire logic [7:0] io_addr,
  input  wire logic [7:0] io_wdata,
  input  wire logic       io_wr,
  input  wire logic       io_rd,
  output logic      [7:0] io_rdata,
  // port logic behind the pins
  input  wire logic       port_data_a,
  input  wire logic       port_dir_a,
  input  wire logic       port_data_b,
  input  wire logic       port_dir_b,
  // interrupt vector taken, one bit per flag
  input  wire logic [2:0] vector_taken,
  // pins and flags
  output logic            compare_out_a_pin,
  output logic            compare_out_a_oe,
  output logic            compare_out_b_pin,
  output logic            compare_out_b_oe,
  output logic            overflow_flag,
  output logic            compare_flag_a,
  output logic            compare_flag_b
);
  import timer2_pkg::*;

  timer2_state_type s_reg;
  timer2_state_type s_next;
  logic             timer_tick;

  // ---------------------------------------------
  // decode helpers
  // ---------------------------------------------
  function automatic wave_kind_type wave_kind(input logic [2:0] mode);
    case (mode)
      `T2_WAVE_NORMAL:  wave_kind = WAVE_NORMAL;
      `T2_WAVE_PC_FF:   wave_kind = WAVE_PHASE;
      `T2_WAVE_CTC:     wave_kind = WAVE_CTC;
      `T2_WAVE_FAST_FF: wave_kind = WAVE_FAST;
      `T2_WAVE_PC_A:    wave_kind = WAVE_PHASE;
      `T2_WAVE_FAST_A:  wave_kind = WAVE_FAST;
      default:          wave_kind = WAVE_RESERVED;
    endcase
  endfunction : wave_kind

  function automatic logic is_pwm(input wave_kind_type kind);
    is_pwm = (kind == WAVE_PHASE) || (kind == WAVE_FAST);
  endfunction : is_pwm

  // action on a compare match; hi enables the toggle code in PWM (channel A only)
  function automatic logic match_action(input logic [1:0]    om,
                                        input wave_kind_type kind,
                                        input logic          hi,
                                        input logic          up,
                                        input logic          cur);
    match_action = cur;
    case (kind)
      WAVE_PHASE:
      begin
        if (om == 2'h2)
        begin
          match_action = !up;
        end
        else if (om == 2'h3)
        begin
          match_action = up;
        end
        else if (om == 2'h1 && hi)
        begin
          match_action = !cur;
        end
      end
      WAVE_FAST:
      begin
        if (om[1])
        begin
          match_action = om[0];
        end
        else if (om == 2'h1 && hi)
        begin
          match_action = !cur;
        end
      end
      WAVE_RESERVED:
      begin
        match_action = cur;
      end
      default:
      begin
        case (om)
          2'h1:    match_action = !cur;
          2'h2:    match_action = 1'b0;
          2'h3:    match_action = 1'b1;
          default: match_action = cur;
        endcase
      end
    endcase
  endfunction : match_action

  // ---------------------------------------------
  // prescaler
  // ---------------------------------------------
  timer2_prescaler u_prescaler (
    .mclk         (mclk),
    .rst_n        (rst_n),
    .clock_select (s_reg.clock_select),
    .timer_tick   (timer_tick)
  );

  // ---------------------------------------------
  // next state
  // ---------------------------------------------
  always_comb
  begin
    wave_kind_type kind;
    wave_kind_type kind_w;
    logic [7:0]    top;
    logic          at_top;
    logic          hit_a;
    logic          hit_b;
    logic          up;
    logic [2:0]    flag_set;
    logic [2:0]    flag_clr;
    logic [2:0]    new_mode;

    s_next   = s_reg;
    kind     = wave_kind(s_reg.wave_mode);
    kind_w   = kind;
    new_mode = s_reg.wave_mode;
    flag_set = 3'h0;
    flag_clr = vector_taken;
    up       = !s_reg.count_down;
    hit_a    = 1'b0;
    hit_b    = 1'b0;
    top      = `T2_MAX;
    at_top   = 1'b0;
    // compare A sets TOP in modes 2, 5 and 7
    if (s_reg.wave_mode == `T2_WAVE_CTC || s_reg.wave_mode == `T2_WAVE_PC_A ||
        s_reg.wave_mode == `T2_WAVE_FAST_A)
    begin
      top = s_reg.cmp_a;
    end
    at_top = (s_reg.count == top);

    // non-PWM modes see compare writes at once
    if (!is_pwm(kind))
    begin
      s_next.cmp_a = s_reg.cmp_a_buf;
      s_next.cmp_b = s_reg.cmp_b_buf;
    end

    if (timer_tick)
    begin
      s_next.match_block = 1'b0;
      hit_a = !s_reg.match_block && (s_reg.count == s_reg.cmp_a);
      hit_b = !s_reg.match_block && (s_reg.count == s_reg.cmp_b);
      flag_set[`T2_FLAG_CMP_A] = hit_a;
      flag_set[`T2_FLAG_CMP_B] = hit_b;
      if (kind == WAVE_PHASE)
      begin
        if (up && at_top)
        begin
          s_next.count_down = 1'b1;
          s_next.count = (top == `T2_BOTTOM) ? `T2_BOTTOM : s_reg.count - 8'h01;
          s_next.cmp_a = s_reg.cmp_a_buf;
          s_next.cmp_b = s_reg.cmp_b_buf;
        end
        else if (up)
        begin
          s_next.count = s_reg.count + 8'h01;
        end
        else if (s_reg.count == `T2_BOTTOM)
        begin
          s_next.count_down = 1'b0;
          s_next.count      = s_reg.count + 8'h01;
          flag_set[`T2_FLAG_OVF] = 1'b1;
        end
        else
        begin
          s_next.count = s_reg.count - 8'h01;
        end
        // a match at TOP is taken as the up-count action
        if (hit_a)
        begin
          s_next.oc_a = match_action(s_reg.out_mode_a, kind, s_reg.wave_mode[2], up,
                                     s_reg.oc_a);
        end
        if (hit_b)
        begin
          s_next.oc_b = match_action(s_reg.out_mode_b, kind, 1'b0, up, s_reg.oc_b);
        end
      end
      else
      begin
        s_next.count_down = 1'b0;
        s_next.count = at_top ? `T2_BOTTOM : s_reg.count + 8'h01;
        if (kind == WAVE_FAST)
        begin
          flag_set[`T2_FLAG_OVF] = at_top;
          if (at_top)
          begin
            s_next.cmp_a = s_reg.cmp_a_buf;
            s_next.cmp_b = s_reg.cmp_b_buf;
          end
          // wrap edge does the bottom action; equal-to-TOP match is dropped when the output mode is clear or set
          if (at_top && s_reg.out_mode_a[1])
          begin
            s_next.oc_a = !s_reg.out_mode_a[0];
          end
          else if (hit_a && !(s_reg.cmp_a == top && s_reg.out_mode_a[1]))
          begin
            s_next.oc_a = match_action(s_reg.out_mode_a, kind, s_reg.wave_mode[2], 1'b1,
                                       s_reg.oc_a);
          end
          if (at_top && s_reg.out_mode_b[1])
          begin
            s_next.oc_b = !s_reg.out_mode_b[0];
          end
          else if (hit_b && !(s_reg.cmp_b == top && s_reg.out_mode_b[1]))
          begin
            s_next.oc_b = match_action(s_reg.out_mode_b, kind, 1'b0, 1'b1, s_reg.oc_b);
          end
        end
        else
        begin
          flag_set[`T2_FLAG_OVF] = (s_reg.count == `T2_MAX);
          if (hit_a)
          begin
            s_next.oc_a = match_action(s_reg.out_mode_a, kind, 1'b0, 1'b1, s_reg.oc_a);
          end
          if (hit_b)
          begin
            s_next.oc_b = match_action(s_reg.out_mode_b, kind, 1'b0, 1'b1, s_reg.oc_b);
          end
        end
      end
    end

    // register writes other than a flag clear take priority over counting
    if (io_wr)
    begin
      case (io_addr)
        `T2_CTRL_A_OFS:
        begin
          s_next.out_mode_a = io_wdata[`T2_A_OUT_MODE_A_HI:`T2_A_OUT_MODE_A_LO];
          s_next.out_mode_b = io_wdata[`T2_A_OUT_MODE_B_HI:`T2_A_OUT_MODE_B_LO];
          s_next.wave_mode[1:0] = io_wdata[`T2_A_WAVE_HI:`T2_A_WAVE_LO];
        end
        `T2_CTRL_B_OFS:
        begin
          new_mode = {io_wdata[`T2_B_WAVE_HIGH], s_reg.wave_mode[1:0]};
          kind_w   = wave_kind(new_mode);
          s_next.wave_mode[2] = io_wdata[`T2_B_WAVE_HIGH];
          s_next.clock_select = io_wdata[`T2_B_CS_HI:`T2_B_CS_LO];
          // strobes only; no flag, no counter clear, nothing stored
          if (!is_pwm(kind_w) && io_wdata[`T2_B_FORCE_A])
          begin
            s_next.oc_a = match_action(s_reg.out_mode_a, kind_w, 1'b0, 1'b1,
                                       s_reg.oc_a);
          end
          if (!is_pwm(kind_w) && io_wdata[`T2_B_FORCE_B])
          begin
            s_next.oc_b = match_action(s_reg.out_mode_b, kind_w, 1'b0, 1'b1,
                                       s_reg.oc_b);
          end
        end
        `T2_COUNT_OFS:
        begin
          s_next.count       = io_wdata;
          s_next.match_block = 1'b1;
        end
        `T2_CMP_A_OFS:
        begin
          s_next.cmp_a_buf = io_wdata;
          if (!is_pwm(kind))
          begin
            s_next.cmp_a = io_wdata;
          end
        end
        `T2_CMP_B_OFS:
        begin
          s_next.cmp_b_buf = io_wdata;
          if (!is_pwm(kind))
          begin
            s_next.cmp_b = io_wdata;
          end
        end
        `T2_FLAGS_OFS:
        begin
          flag_clr = flag_clr | io_wdata[2:0];
        end
        default:
        begin
        end
      endcase
    end
    // set wins over a clear in the same cycle
    s_next.flags = (s_reg.flags & ~flag_clr) | flag_set;

    if (io_rd)
    begin
      case (io_addr)
        `T2_CTRL_A_OFS: s_next.rdata = {s_reg.out_mode_a, s_reg.out_mode_b, 2'h0,
                                        s_reg.wave_mode[1:0]};
        `T2_CTRL_B_OFS: s_next.rdata = {2'h0, 2'h0, s_reg.wave_mode[2],
                                        s_reg.clock_select};
        `T2_COUNT_OFS:  s_next.rdata = s_reg.count;
        `T2_CMP_A_OFS:  s_next.rdata = s_reg.cmp_a_buf;
        `T2_CMP_B_OFS:  s_next.rdata = s_reg.cmp_b_buf;
        `T2_FLAGS_OFS:  s_next.rdata = {5'h00, s_reg.flags};
        default:        s_next.rdata = `T2_RESET_BYTE;
      endcase
    end

    // pin override; the port direction bit still gates the driver
    s_next.pin_a    = (s_next.out_mode_a != 2'h0) ? s_next.oc_a : port_data_a;
    s_next.pin_a_oe = port_dir_a;
    s_next.pin_b    = (s_next.out_mode_b != 2'h0) ? s_next.oc_b : port_data_b;
    s_next.pin_b_oe = port_dir_b;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ---------------------------------------------
  // outputs
  // ---------------------------------------------
  assign io_rdata          = s_reg.rdata;
  assign compare_out_a_pin = s_reg.pin_a;
  assign compare_out_a_oe  = s_reg.pin_a_oe;
  assign compare_out_b_pin = s_reg.pin_b;
  assign compare_out_b_oe  = s_reg.pin_b_oe;
  assign overflow_flag     = s_reg.flags[`T2_FLAG_OVF];
  assign compare_flag_a    = s_reg.flags[`T2_FLAG_CMP_A];
  assign compare_flag_b    = s_reg.flags[`T2_FLAG_CMP_B];

endmodule : timer2_waveform_control

// file: inc/timer2_regs.svh
`ifndef TIMER2_REGS_SVH
`define TIMER2_REGS_SVH

// ---------------------------------------------
// register offsets
// ---------------------------------------------
`define T2_CTRL_A_OFS      8'hB0
`define T2_CTRL_B_OFS      8'hB1
`define T2_COUNT_OFS       8'hB2
`define T2_CMP_A_OFS       8'hB3
`define T2_CMP_B_OFS       8'hB4
`define T2_FLAGS_OFS       8'h37

// ---------------------------------------------
// field positions
// ---------------------------------------------
`define T2_A_OUT_MODE_A_HI 7
`define T2_A_OUT_MODE_A_LO 6
`define T2_A_OUT_MODE_B_HI 5
`define T2_A_OUT_MODE_B_LO 4
`define T2_A_WAVE_HI       1
`define T2_A_WAVE_LO       0
`define T2_B_FORCE_A       7
`define T2_B_FORCE_B       6
`define T2_B_WAVE_HIGH     3
`define T2_B_CS_HI         2
`define T2_B_CS_LO         0
`define T2_FLAG_OVF        0
`define T2_FLAG_CMP_A      1
`define T2_FLAG_CMP_B      2

// ---------------------------------------------
// reset values and counter limits
// ---------------------------------------------
`define T2_RESET_BYTE      8'h00
`define T2_MAX             8'hFF
`define T2_BOTTOM          8'h00

// ---------------------------------------------
// waveform mode codes
// ---------------------------------------------
`define T2_WAVE_NORMAL     3'h0
`define T2_WAVE_PC_FF      3'h1
`define T2_WAVE_CTC        3'h2
`define T2_WAVE_FAST_FF    3'h3
`define T2_WAVE_PC_A       3'h5
`define T2_WAVE_FAST_A     3'h7

// ---------------------------------------------
// prescaler tap masks (divide minus one)
// ---------------------------------------------
`define T2_PRE_DIV8        10'h007
`define T2_PRE_DIV32       10'h01F
`define T2_PRE_DIV64       10'h03F
`define T2_PRE_DIV128      10'h07F
`define T2_PRE_DIV256      10'h0FF
`define T2_PRE_DIV1024     10'h3FF

`endif

// file: inc/timer2_pkg.sv
package timer2_pkg;

  // ---------------------------------------------
  // types
  // ---------------------------------------------
  typedef enum logic [2:0] {
    WAVE_NORMAL,
    WAVE_PHASE,
    WAVE_CTC,
    WAVE_FAST,
    WAVE_RESERVED
  } wave_kind_type;

  typedef struct packed {
    logic [9:0] div_count;
  } prescale_state_type;

  typedef struct packed {
    logic [1:0] out_mode_a;
    logic [1:0] out_mode_b;
    logic [2:0] wave_mode;
    logic [2:0] clock_select;
    logic [7:0] count;
    logic [7:0] cmp_a;
    logic [7:0] cmp_b;
    logic [7:0] cmp_a_buf;
    logic [7:0] cmp_b_buf;
    logic [2:0] flags;
    logic       count_down;
    logic       match_block;
    logic       oc_a;
    logic       oc_b;
    logic       pin_a;
    logic       pin_a_oe;
    logic       pin_b;
    logic       pin_b_oe;
    logic [7:0] rdata;
  } timer2_state_type;

endpackage : timer2_pkg

// file: design/timer2_prescaler.sv
`timescale 1ns/100ps
`include "timer2_regs.svh"

module timer2_prescaler
  import timer2_pkg::*;
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // select and tick
  input  wire logic [2:0] clock_select,
  output logic            timer_tick
);
  import timer2_pkg::*;

  prescale_state_type s_reg;
  prescale_state_type s_next;

  // ---------------------------------------------
  // tap decode
  // ---------------------------------------------
  function automatic logic tap_hit(input logic [2:0] sel, input logic [9:0] cnt);
    logic [9:0] mask;
    mask = 10'h000;
    case (sel)
      3'h2:    mask = `T2_PRE_DIV8;
      3'h3:    mask = `T2_PRE_DIV32;
      3'h4:    mask = `T2_PRE_DIV64;
      3'h5:    mask = `T2_PRE_DIV128;
      3'h6:    mask = `T2_PRE_DIV256;
      3'h7:    mask = `T2_PRE_DIV1024;
      default: mask = 10'h000;
    endcase
    // code 0 stops the timer, code 1 ticks every clock
    if (sel == 3'h0)
    begin
      tap_hit = 1'b0;
    end
    else
    begin
      tap_hit = ((cnt & mask) == mask);
    end
  endfunction : tap_hit

  // free running; taps share one counter so a select change never waits long
  always_comb
  begin
    s_next           = s_reg;
    s_next.div_count = s_reg.div_count + 10'h001;
    timer_tick       = tap_hit(clock_select, s_reg.div_count);
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

endmodule : timer2_prescaler

// file: tb/timer2_waveform_checker.sv
`timescale 1ns/100ps
// ----------------------------------------
// port checker for the timer2 block
// ----------------------------------------
module timer2_waveform_checker
(
  // clock and reset
  input wire logic       mclk,
  input wire logic       rst_n,
  // register port
  input wire logic [7:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic       io_wr,
  input wire logic       io_rd,
  input wire logic [7:0] io_rdata,
  // pin b and flags
  input wire logic       port_data_b,
  input wire logic       port_dir_b,
  input wire logic [2:0] vector_taken,
  input wire logic       compare_out_b_pin,
  input wire logic       compare_out_b_oe,
  input wire logic       overflow_flag,
  input wire logic       compare_flag_a,
  input wire logic       compare_flag_b
);
  logic [7:0] ctrl_a_reg;
  logic [7:0] ctrl_b_reg;
  logic       stop;

  // shadows as software sees them; unused bits read zero
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      ctrl_a_reg <= 8'h00;
      ctrl_b_reg <= 8'h00;
    end
    else if (io_wr && io_addr == 8'hB0)
      ctrl_a_reg <= io_wdata & 8'hF3;
    else if (io_wr && io_addr == 8'hB1)
      ctrl_b_reg <= io_wdata & 8'h0F;

  assign stop = ctrl_b_reg[2:0] == 3'h0;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  chk_ctrl_a_read:
    assert property (io_rd && io_addr == 8'hB0 |=> io_rdata == $past(ctrl_a_reg))
    else $error("control a read back wrong");
  chk_force_reads_zero:
    assert property (io_rd && io_addr == 8'hB1 |=> io_rdata == $past(ctrl_b_reg))
    else $error("control b read back wrong");
  chk_rdata_holds:
    assert property (!io_rd |=> $stable(io_rdata))
    else $error("read data moved without a read");
  chk_dir_enables:
    assert property ($past(rst_n) |-> compare_out_b_oe == $past(port_dir_b))
    else $error("pin b enable not following direction");
  chk_port_when_off:
    assert property (ctrl_a_reg[5:4] == 2'b00 ##1 ctrl_a_reg[5:4] == 2'b00
                     |-> compare_out_b_pin == $past(port_data_b))
    else $error("pin b not port data while disconnected");
  chk_vector_clears:
    assert property (stop && $past(stop) && vector_taken[0] |=> !overflow_flag)
    else $error("overflow flag kept after vector");
  chk_flag_w1c:
    assert property (stop && $past(stop) && io_wr && io_addr == 8'h37 && io_wdata[0]
                     |=> !overflow_flag)
    else $error("overflow flag kept after write one");
  chk_force_no_flag:
    assert property (stop && $past(stop) && io_wr && io_addr == 8'hB1 && io_wdata[2:0] == 3'h0
                     |=> (!$rose(compare_flag_a) && !$rose(compare_flag_b)) [*2])
    else $error("forced compare raised a flag");
  chk_ovf_cause:
    assert property ($rose(overflow_flag) |-> !($past(stop) && $past(stop, 2)))
    else $error("overflow flag set with clock stopped");

  cover property (io_rd && io_addr == 8'hB2);
  cover property ($rose(overflow_flag));
  cover property ($rose(compare_out_b_pin));
endmodule : timer2_waveform_checker

// file: tb/timer2_waveform_control_test.sv
`timescale 1ns/100ps
// ----------------------------------------
// bench for the timer2 block
// ----------------------------------------
module timer2_waveform_control_test;
  logic       mclk = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] io_addr = 8'h00;
  logic [7:0] io_wdata = 8'h00;
  logic       io_wr = 1'b0;
  logic       io_rd = 1'b0;
  logic [7:0] io_rdata;
  logic       port_data_a = 1'b0;
  logic       port_dir_a = 1'b0;
  logic       port_data_b = 1'b0;
  logic       port_dir_b = 1'b0;
  logic [2:0] vector_taken = 3'h0;
  logic       pin_a;
  logic       oe_a;
  logic       pin_b;
  logic       oe_b;
  logic       ovf;
  logic       flag_a;
  logic       flag_b;
  logic [7:0] v;
  int         errors = 0;
  int         n_tests = 0;
  int         n_high;
  int         divs [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
  logic [1:0] fmode [4] = '{2'h3, 2'h2, 2'h1, 2'h1};
  logic       fpin [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  // pwm table: control a, control b, compare b, window, lowest high count
  logic [7:0] t_a [8] = '{8'h23, 8'h33, 8'h23, 8'h21, 8'h31, 8'h21, 8'h23, 8'h12};
  logic [7:0] t_b [8] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h09, 8'h09, 8'h01};
  logic [7:0] t_c [8] = '{8'h40, 8'h40, 8'hFF, 8'h40, 8'h40, 8'h40, 8'h40, 8'h10};
  int         t_w [8] = '{256, 256, 256, 510, 510, 254, 256, 256};
  int         t_lo [8] = '{63, 189, 256, 126, 380, 126, 128, 126};

  timer2_waveform_control dut
  (
    .mclk, .rst_n, .io_addr, .io_wdata, .io_wr, .io_rd, .io_rdata,
    .port_data_a, .port_dir_a, .port_data_b, .port_dir_b, .vector_taken,
    .compare_out_a_pin (pin_a),
    .compare_out_a_oe  (oe_a),
    .compare_out_b_pin (pin_b),
    .compare_out_b_oe  (oe_b),
    .overflow_flag     (ovf),
    .compare_flag_a    (flag_a),
    .compare_flag_b    (flag_b)
  );

  always #10 mclk = ~mclk;

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    io_addr  <= a;
    io_wdata <= d;
    io_wr    <= 1'b1;
    @(posedge mclk);
    io_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    io_addr <= a;
    io_rd   <= 1'b1;
    @(posedge mclk);
    io_rd <= 1'b0;
    #1 d = io_rdata;
  endtask : rd

  task automatic summarize;
    if (errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize

  // ----------------------------------------
  // watchdog, about 1.7 times the run
  // ----------------------------------------
  initial
  begin
    repeat (40000) @(posedge mclk);
    errors++;
    summarize();
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      rd(8'hB0 + i[7:0], v);
      check("reset value", v, 8'h00);
    end
    wr(8'hB0, 8'hFF);
    rd(8'hB0, v);
    check("control a", v, 8'hF3);
    wr(8'hB1, 8'hC8);
    rd(8'hB1, v);
    check("control b", v, 8'h08);
    check("pwm force", pin_b, 1'b0);
    rd(8'hB5, v);
    check("unmapped", v, 8'h00);
    wr(8'hB1, 8'h00);
    wr(8'hB0, 8'h00);
    wr(8'hB2, 8'h5A);
    rd(8'hB2, v);
    check("count", v, 8'h5A);
    @(posedge mclk);
    port_dir_a  <= 1'b1;
    port_dir_b  <= 1'b1;
    port_data_a <= 1'b1;
    port_data_b <= 1'b1;
    repeat (2) @(posedge mclk);
    #1 check("port b", pin_b, 1'b1);
    check("drive b", oe_b, 1'b1);
    check("port a", pin_a, 1'b1);
    check("drive a", oe_a, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      wr(8'hB0, {2'b00, fmode[i], 4'h0});
      wr(8'hB1, 8'h40);
      @(posedge mclk);
      #1 check("forced b", pin_b, fpin[i]);
    end
    check("force flag", flag_b, 1'b0);
    // a write to the count must hide the match on the next tick
    wr(8'hB4, 8'h40);
    wr(8'hB2, 8'h40);
    wr(8'hB1, 8'h01);
    repeat (5) @(posedge mclk);
    wr(8'hB1, 8'h00);
    check("blocked match", flag_b, 1'b0);
    wr(8'hB2, 8'h3F);
    wr(8'hB1, 8'h01);
    repeat (5) @(posedge mclk);
    wr(8'hB1, 8'h00);
    check("match flag", flag_b, 1'b1);
    wr(8'hB2, 8'hFD);
    wr(8'hB1, 8'h01);
    repeat (8) @(posedge mclk);
    wr(8'hB1, 8'h00);
    repeat (2) @(posedge mclk);
    #1 check("overflow", ovf, 1'b1);
    @(posedge mclk);
    vector_taken <= 3'h5;
    @(posedge mclk);
    vector_taken <= 3'h0;
    repeat (2) @(posedge mclk);
    #1 check("vector ovf", ovf, 1'b0);
    check("vector b", flag_b, 1'b0);
    // compare A matched at the wrap through zero; its vector bit stayed low
    check("vector a kept", flag_a, 1'b1);
    wr(8'hB1, 8'h01);
    repeat (260) @(posedge mclk);
    wr(8'hB1, 8'h00);
    repeat (2) @(posedge mclk);
    #1 check("wrap", ovf, 1'b1);
    wr(8'h37, 8'h01);
    check("write one", ovf, 1'b0);
    for (int i = 1; i < 8; i++)
    begin
      wr(8'hB1, i[7:0]);
      wr(8'hB2, 8'h00);
      repeat (10 * divs[i] - 2) @(posedge mclk);
      rd(8'hB2, v);
      check("prescaled", v >= 8'h09 && v <= 8'h0B, 1'b1);
    end
    wr(8'hB1, 8'h00);
    wr(8'hB2, 8'h77);
    repeat (50) @(posedge mclk);
    rd(8'hB2, v);
    check("stopped", v, 8'h77);
    // duty measured over whole periods, after two windows to settle
    wr(8'hB3, 8'h7F);
    for (int r = 0; r < 8; r++)
    begin
      wr(8'hB4, t_c[r]);
      wr(8'hB0, t_a[r]);
      wr(8'hB1, t_b[r]);
      repeat (2 * t_w[r]) @(posedge mclk);
      n_high = 0;
      repeat (t_w[r])
      begin
        @(posedge mclk);
        #1 if (pin_b === 1'b1) n_high++;
      end
      check("duty", n_high >= t_lo[r] && n_high <= t_lo[r] + 4, 1'b1);
    end
    summarize();
  end
endmodule : timer2_waveform_control_test

bind timer2_waveform_control timer2_waveform_checker chk
(
  .mclk, .rst_n, .io_addr, .io_wdata, .io_wr, .io_rd, .io_rdata,
  .port_data_b, .port_dir_b, .vector_taken, .compare_out_b_pin,
  .compare_out_b_oe, .overflow_flag, .compare_flag_a, .compare_flag_b
);
